//--- common/asrc_pkg.sv
// package: constants for the analog speed reference conditioner
//
// Contract
// - voltage active span maps linearly to frequencies
// - voltage start/end freq 0..400 Hz, default 0
// - span percentages 0..100, defaults 0 and 100
// - voltage below span: 00 start freq, 01 zero
// - voltage above span clamps to end freq
// - current span maps linearly to own frequencies
// - current below span: start freq or zero
// - current above span clamps to end freq
// - selector codes 00..03 choose or sum inputs
// - settings 1..16 give n-sample moving average
// - setting 17: 16-sample average then deadband
// - ignore change under +0.1 or -0.2 Hz
// - beyond deadband apply and store new point
// - voltage settings never touch potentiometer path
// - output used when source select is 01
package asrc_pkg;
  localparam int ASRC_FREQ_W = 12;
  localparam int ASRC_PCT_W = 7;
  localparam int ASRC_ADC_W = 10;
  localparam logic [11:0] ASRC_FREQ_MAX = 12'h0FA0;
  localparam logic [6:0] ASRC_PCT_MAX = 7'h64;
  localparam logic [11:0] ASRC_START_FREQ_RST = 12'h0000;
  localparam logic [11:0] ASRC_END_FREQ_RST = 12'h0000;
  localparam logic [6:0] ASRC_START_PCT_RST = 7'h00;
  localparam logic [6:0] ASRC_END_PCT_RST = 7'h64;
  localparam logic [1:0] ASRC_BELOW_START = 2'h0;
  localparam logic [1:0] ASRC_BELOW_ZERO = 2'h1;
  localparam logic [1:0] ASRC_BELOW_RST = 2'h1;
  localparam logic [1:0] ASRC_SEL_TERM_VI = 2'h0;
  localparam logic [1:0] ASRC_SEL_SUM = 2'h1;
  localparam logic [1:0] ASRC_SEL_TERM_VP = 2'h2;
  localparam logic [1:0] ASRC_SEL_TERM_IP = 2'h3;
  localparam logic [1:0] ASRC_SEL_RST = 2'h0;
  localparam logic [4:0] ASRC_FILT_DEADBAND = 5'h11;
  localparam logic [4:0] ASRC_FILT_MAXN = 5'h10;
  localparam logic [4:0] ASRC_FILT_RST = 5'h08;
  localparam logic [11:0] ASRC_DB_UP = 12'h0001;
  localparam logic [11:0] ASRC_DB_DOWN = 12'h0002;
  localparam logic [2:0] ASRC_SRC_TERMINAL = 3'h1;
  localparam int ASRC_HIST_DEPTH = 16;
endpackage

//--- hdl/asrc_scale.sv
// module: one analog input span scaler
`timescale 1ns/10ps
`default_nettype none
module asrc_scale
  import asrc_pkg::*;
(
  input wire logic [ASRC_ADC_W-1:0] sample,
  input wire logic [ASRC_FREQ_W-1:0] start_freq,
  input wire logic [ASRC_FREQ_W-1:0] end_freq,
  input wire logic [ASRC_PCT_W-1:0] start_pct,
  input wire logic [ASRC_PCT_W-1:0] end_pct,
  input wire logic [1:0] below_range_select,
  output logic [ASRC_FREQ_W-1:0] freq
);
  // input as tenths of a percent, 0..1000, avoids a divide by full scale in the span
  logic [19:0] pm;
  logic [10:0] lo;
  logic [10:0] hi;
  logic [10:0] span;
  logic [10:0] pos;
  logic signed [13:0] dfreq;
  logic signed [25:0] prod;
  logic signed [25:0] quo;
  logic signed [14:0] res;
  always_comb begin
    pm = (20'(sample) * 20'd1000) / 20'(((1 << ASRC_ADC_W) - 1));
    lo = 11'(start_pct) * 11'd10;
    hi = 11'(end_pct) * 11'd10;
    span = (hi > lo) ? hi - lo : 11'd1;
    pos = pm[10:0] - lo;
    dfreq = $signed({2'b00, end_freq}) - $signed({2'b00, start_freq});
    prod = 26'(dfreq) * $signed({15'd0, pos});
    quo = prod / $signed({15'd0, span});
    res = 15'($signed({3'b000, start_freq})) + 15'(quo);
    if (pm[10:0] < lo) begin
      freq = (below_range_select == ASRC_BELOW_START) ? start_freq : '0;
    end else if (pm[10:0] >= hi) begin
      freq = end_freq;
    end else if (res < 0) begin
      freq = '0;
    end else begin
      freq = res[ASRC_FREQ_W-1:0];
    end
  end
endmodule // asrc_scale
`default_nettype wire

//--- hdl/asrc_top.sv
// module: analog speed reference conditioner top
`timescale 1ns/10ps
`default_nettype none
module asrc_top
  import asrc_pkg::*;
#(
  parameter int DEPTH = ASRC_HIST_DEPTH
)(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic sample_en,
  input wire logic [ASRC_ADC_W-1:0] volt_input,
  input wire logic [ASRC_ADC_W-1:0] current_input,
  input wire logic [ASRC_FREQ_W-1:0] pot_freq,
  input wire logic input_choice_terminal,
  input wire logic cfg_load,
  input wire logic [1:0] input_selector_code,
  input wire logic [ASRC_FREQ_W-1:0] volt_start_freq,
  input wire logic [ASRC_FREQ_W-1:0] volt_end_freq,
  input wire logic [ASRC_PCT_W-1:0] volt_start_pct,
  input wire logic [ASRC_PCT_W-1:0] volt_end_pct,
  input wire logic [1:0] volt_below_range_select,
  input wire logic [4:0] filter_sample_setting,
  input wire logic [ASRC_FREQ_W-1:0] curr_start_freq,
  input wire logic [ASRC_FREQ_W-1:0] curr_end_freq,
  input wire logic [ASRC_PCT_W-1:0] curr_start_pct,
  input wire logic [ASRC_PCT_W-1:0] curr_end_pct,
  input wire logic [1:0] curr_below_range_select,
  input wire logic [2:0] freq_source_select,
  output logic [ASRC_FREQ_W-1:0] freq_ref,
  output logic freq_ref_valid,
  output logic freq_ref_active
);
  typedef struct packed {
    logic [1:0] sel;
    logic [11:0] vsf;
    logic [11:0] vef;
    logic [6:0] vsp;
    logic [6:0] vep;
    logic [1:0] vbr;
    logic [4:0] filt;
    logic [11:0] csf;
    logic [11:0] cef;
    logic [6:0] csp;
    logic [6:0] cep;
    logic [1:0] cbr;
    logic [DEPTH-1:0][11:0] hist;
    logic [4:0] fill;
    logic [11:0] point;
    logic primed;
    logic [11:0] out;
    logic valid;
    logic term_s1;
    logic term_s2;
  } asrc_state_t;

  asrc_state_t st_reg;
  asrc_state_t st_next;

  logic [11:0] v_freq;
  logic [11:0] c_freq;
  logic [11:0] mixed;
  logic [15:0] acc;
  logic [4:0] n;
  logic [11:0] avg;
  logic [ASRC_FREQ_W-1:0] mx_hist [DEPTH];

  function automatic logic [11:0] asrc_clip(input logic [12:0] v, input logic [11:0] lim);
    asrc_clip = (v > {1'b0, lim}) ? lim : v[11:0];
  endfunction

  asrc_scale u_volt (
    .sample(volt_input),
    .start_freq(st_reg.vsf),
    .end_freq(st_reg.vef),
    .start_pct(st_reg.vsp),
    .end_pct(st_reg.vep),
    .below_range_select(st_reg.vbr),
    .freq(v_freq)
  );

  asrc_scale u_curr (
    .sample(current_input),
    .start_freq(st_reg.csf),
    .end_freq(st_reg.cef),
    .start_pct(st_reg.csp),
    .end_pct(st_reg.cep),
    .below_range_select(st_reg.cbr),
    .freq(c_freq)
  );

  always_comb begin
    // selector terminal passes a two-flop synchroniser in the state
    case (st_reg.sel)
      ASRC_SEL_TERM_VI: mixed = st_reg.term_s2 ? c_freq : v_freq;
      ASRC_SEL_SUM: mixed = asrc_clip({1'b0, v_freq} + {1'b0, c_freq}, ASRC_FREQ_MAX);
      ASRC_SEL_TERM_VP: mixed = st_reg.term_s2 ? pot_freq : v_freq;
      ASRC_SEL_TERM_IP: mixed = st_reg.term_s2 ? pot_freq : c_freq;
      default: mixed = v_freq;
    endcase
  end

  always_comb begin
    st_next = st_reg;
    st_next.term_s1 = input_choice_terminal;
    st_next.term_s2 = st_reg.term_s1;
    st_next.valid = 1'b0;
    if (cfg_load) begin
      st_next.sel = input_selector_code;
      st_next.vsf = asrc_clip({1'b0, volt_start_freq}, ASRC_FREQ_MAX);
      st_next.vef = asrc_clip({1'b0, volt_end_freq}, ASRC_FREQ_MAX);
      st_next.vsp = (volt_start_pct > ASRC_PCT_MAX) ? ASRC_PCT_MAX : volt_start_pct;
      st_next.vep = (volt_end_pct > ASRC_PCT_MAX) ? ASRC_PCT_MAX : volt_end_pct;
      st_next.vbr = volt_below_range_select;
      st_next.filt = (filter_sample_setting == 5'h00) ? 5'h01 :
                     (filter_sample_setting > ASRC_FILT_DEADBAND) ? ASRC_FILT_DEADBAND : filter_sample_setting;
      st_next.csf = asrc_clip({1'b0, curr_start_freq}, ASRC_FREQ_MAX);
      st_next.cef = asrc_clip({1'b0, curr_end_freq}, ASRC_FREQ_MAX);
      st_next.csp = (curr_start_pct > ASRC_PCT_MAX) ? ASRC_PCT_MAX : curr_start_pct;
      st_next.cep = (curr_end_pct > ASRC_PCT_MAX) ? ASRC_PCT_MAX : curr_end_pct;
      st_next.cbr = curr_below_range_select;
    end
    if (sample_en) begin
      st_next.hist[0] = mixed;
      for (int i = 1; i < DEPTH; i++) begin
        st_next.hist[i] = st_reg.hist[i-1];
      end
      if (st_reg.fill < ASRC_FILT_MAXN) begin
        st_next.fill = st_reg.fill + 5'h01;
      end
    end
    // average over the window including the new sample; early samples use what exists
    for (int i = 0; i < DEPTH; i++) begin
      mx_hist[i] = st_next.hist[i];
    end
    n = (st_reg.filt >= ASRC_FILT_MAXN) ? ASRC_FILT_MAXN : st_reg.filt;
    if (n > st_next.fill) begin
      n = st_next.fill;
    end
    if (n == 5'h00) begin
      n = 5'h01;
    end
    acc = '0;
    for (int i = 0; i < DEPTH; i++) begin
      if (5'(i) < n) begin
        acc = acc + 16'(mx_hist[i]);
      end
    end
    // divide truncates, so an average between counts reads up to one count low; a settled constant input is exact
    avg = 12'(acc / 16'(n));
    if (sample_en) begin
      st_next.valid = 1'b1;
      if (st_reg.filt != ASRC_FILT_DEADBAND) begin
        st_next.out = avg;
        st_next.primed = 1'b0;
      end else if (!st_reg.primed) begin
        // first average after entering deadband mode is applied directly, however few samples it holds
        st_next.out = avg;
        st_next.point = avg;
        st_next.primed = 1'b1;
        // a step exactly at the band edge is still ignored
      end else if ((avg > st_reg.point && avg - st_reg.point > ASRC_DB_UP) ||
                   (avg < st_reg.point && st_reg.point - avg > ASRC_DB_DOWN)) begin
        st_next.out = avg;
        st_next.point = avg;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= '0;
      st_reg.sel <= ASRC_SEL_RST;
      st_reg.vsf <= ASRC_START_FREQ_RST;
      st_reg.vef <= ASRC_END_FREQ_RST;
      st_reg.vsp <= ASRC_START_PCT_RST;
      st_reg.vep <= ASRC_END_PCT_RST;
      st_reg.vbr <= ASRC_BELOW_RST;
      st_reg.filt <= ASRC_FILT_RST;
      st_reg.csf <= ASRC_START_FREQ_RST;
      st_reg.cef <= ASRC_END_FREQ_RST;
      st_reg.csp <= ASRC_START_PCT_RST;
      st_reg.cep <= ASRC_END_PCT_RST;
      st_reg.cbr <= ASRC_BELOW_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign freq_ref = st_reg.out;
  assign freq_ref_valid = st_reg.valid;
  assign freq_ref_active = (freq_source_select == ASRC_SRC_TERMINAL);

  valid_follows_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    sample_en |=> freq_ref_valid) else $error("no valid after sample");
  valid_cause_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    freq_ref_valid |-> $past(sample_en)) else $error("spurious valid");
  hold_no_sample_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    !sample_en |=> $stable(freq_ref)) else $error("output moved without sample");
  single_avg_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sample_en && st_reg.filt == 5'h01) |=> freq_ref == $past(mixed)) else $error("n=1 not passthrough");
  // both edges of the band are held, up and down
  deadband_hold_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sample_en && st_reg.filt == ASRC_FILT_DEADBAND && st_reg.primed &&
     avg <= st_reg.point + ASRC_DB_UP && avg + ASRC_DB_DOWN >= st_reg.point)
    |=> $stable(freq_ref)) else $error("deadband not held");
  deadband_move_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (sample_en && st_reg.filt == ASRC_FILT_DEADBAND && st_reg.primed && st_reg.point > ASRC_DB_DOWN &&
     avg < st_reg.point - ASRC_DB_DOWN) |=> freq_ref == $past(avg) && st_reg.point == $past(avg))
    else $error("deadband step not applied");
  clamp_high_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    v_freq <= ASRC_FREQ_MAX && c_freq <= ASRC_FREQ_MAX) else $error("scaled freq over limit");
  sum_mode_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    (st_reg.sel == ASRC_SEL_SUM && 13'(v_freq) + 13'(c_freq) <= 13'(ASRC_FREQ_MAX))
    |-> mixed == v_freq + c_freq) else $error("sum mode wrong");
  active_src_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    freq_ref_active == (freq_source_select == 3'h1)) else $error("source select wrong");
  cfg_clamp_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    cfg_load |=> st_reg.vef <= ASRC_FREQ_MAX && st_reg.cef <= ASRC_FREQ_MAX &&
    st_reg.vep <= ASRC_PCT_MAX && st_reg.cep <= ASRC_PCT_MAX) else $error("setting over range");
  fill_bound_a: assert property (@(posedge sys_clk) disable iff (!rst_b)
    st_reg.fill <= ASRC_FILT_MAXN) else $error("fill count over window");
endmodule // asrc_top
`default_nettype wire

//--- test/asrc_front_model.sv
// partner model: analog front end handing sampled codes to the conditioner
`timescale 1ns/10ps
`default_nettype none
module asrc_front_model
  import asrc_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic req,
  input wire logic slow,
  input wire logic [ASRC_ADC_W-1:0] volt_code,
  input wire logic [ASRC_ADC_W-1:0] curr_code,
  output logic sample_en,
  output logic [ASRC_ADC_W-1:0] volt_input,
  output logic [ASRC_ADC_W-1:0] current_input
);
  logic pend_reg;
  // codes move only with a request, so one strobe never mixes two conversions
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      pend_reg <= 1'b0;
      sample_en <= 1'b0;
      volt_input <= 10'h000;
      current_input <= 10'h000;
    end else begin
      pend_reg <= req;
      sample_en <= slow ? pend_reg : req;
      if (req) begin
        volt_input <= volt_code;
        current_input <= curr_code;
      end
    end
  end
endmodule // asrc_front_model
`default_nettype wire

//--- test/asrc_top_tb.sv
// testbench: analog speed reference conditioner
`timescale 1ns/10ps
`default_nettype none
module asrc_top_tb;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic req = 1'b0, slow = 1'b0, term = 1'b0, cfg_load = 1'b0;
  logic [9:0] vc = 10'h000, cc = 10'h000;
  logic [11:0] pot = 12'h000, vsf = 12'h000, vef = 12'h000, csf = 12'h000, cef = 12'h000;
  logic [6:0] vsp = 7'h00, vep = 7'h64, csp = 7'h00, cep = 7'h64;
  logic [1:0] sel = 2'h0, vbr = 2'h1, cbr = 2'h1;
  logic [4:0] filt = 5'h01;
  logic [2:0] fss = 3'h0;
  logic sample_en, freq_ref_valid, freq_ref_active;
  logic [9:0] volt_input, current_input;
  logic [11:0] freq_ref;
  logic [11:0] sel_exp [8] = '{12'h03E8, 12'h01F4, 12'h05DC, 12'h05DC, 12'h03E8, 12'h007B, 12'h01F4, 12'h007B};
  logic [11:0] avg_in [5] = '{12'h03E8, 12'h0000, 12'h0000, 12'h0000, 12'h0000};
  logic [11:0] avg_exp [5] = '{12'h03E8, 12'h01F4, 12'h014D, 12'h00FA, 12'h0000};
  logic [11:0] db_in [4] = '{12'h03F8, 12'h03F8, 12'h03C8, 12'h03C8};
  logic [11:0] db_exp [4] = '{12'h03E8, 12'h03EA, 12'h03EA, 12'h03E6};
  int failures = 0, check_count = 0;
  always #10 sys_clk = ~sys_clk;
  asrc_front_model front_u (.sys_clk(sys_clk), .rst_b(rst_b), .req(req), .slow(slow), .volt_code(vc),
    .curr_code(cc), .sample_en(sample_en), .volt_input(volt_input), .current_input(current_input));
  asrc_top dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .sample_en(sample_en), .volt_input(volt_input),
    .current_input(current_input), .pot_freq(pot), .input_choice_terminal(term), .cfg_load(cfg_load),
    .input_selector_code(sel), .volt_start_freq(vsf), .volt_end_freq(vef), .volt_start_pct(vsp),
    .volt_end_pct(vep), .volt_below_range_select(vbr), .filter_sample_setting(filt),
    .curr_start_freq(csf), .curr_end_freq(cef), .curr_start_pct(csp), .curr_end_pct(cep),
    .curr_below_range_select(cbr), .freq_source_select(fss), .freq_ref(freq_ref),
    .freq_ref_valid(freq_ref_valid), .freq_ref_active(freq_ref_active));
  task automatic chk(string nm, logic [11:0] seen, logic [11:0] exp);
    check_count++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic rst;
    @(posedge sys_clk);
    rst_b <= 1'b0;
    repeat (20) @(posedge sys_clk);
    rst_b <= 1'b1;
  endtask
  task automatic load;
    @(posedge sys_clk);
    cfg_load <= 1'b1;
    @(posedge sys_clk);
    cfg_load <= 1'b0;
  endtask
  // terminal settles one edge early; the sync flops need two cycles
  task automatic samp(logic [9:0] v, logic [9:0] c, logic [11:0] p, logic t, logic [11:0] exp);
    int n;
    @(posedge sys_clk);
    term <= t;
    pot <= p;
    @(posedge sys_clk);
    vc <= v;
    cc <= c;
    req <= 1'b1;
    @(posedge sys_clk);
    req <= 1'b0;
    n = 0;
    do begin
      @(posedge sys_clk);
      #1;
      n++;
    end while (freq_ref_valid !== 1'b1 && n < 8);
    chk("freq_ref", freq_ref, exp);
    chk("valid_high", {11'h000, freq_ref_valid}, 12'h001);
    @(posedge sys_clk);
    #1;
    chk("valid_low", {11'h000, freq_ref_valid}, 12'h000);
  endtask
  task automatic t_defaults;
    rst;
    samp(10'h3FF, 10'h3FF, 12'h0000, 1'b0, 12'h0000);
    chk("active_off", {11'h000, freq_ref_active}, 12'h000);
    @(posedge sys_clk);
    fss <= 3'h1;
    @(posedge sys_clk);
    #1;
    chk("active_on", {11'h000, freq_ref_active}, 12'h001);
  endtask
  task automatic t_scale;
    vef <= 12'hFFF;
    load;
    samp(10'h3FF, 10'h000, 12'h0000, 1'b0, 12'h0FA0);
    vef <= 12'h03E8;
    load;
    samp(10'h200, 10'h000, 12'h0000, 1'b0, 12'h01F4);
    vep <= 7'h32;
    load;
    samp(10'h3FF, 10'h000, 12'h0000, 1'b0, 12'h03E8);
    vsp <= 7'h32;
    vsf <= 12'h00C8;
    vbr <= 2'h0;
    load;
    samp(10'h000, 10'h000, 12'h0000, 1'b0, 12'h00C8);
    vbr <= 2'h1;
    load;
    samp(10'h000, 10'h000, 12'h0000, 1'b0, 12'h0000);
    csp <= 7'h32;
    cep <= 7'h7F;
    csf <= 12'h0064;
    cef <= 12'h01F4;
    cbr <= 2'h0;
    load;
    samp(10'h000, 10'h3FF, 12'h0000, 1'b1, 12'h01F4);
    samp(10'h000, 10'h000, 12'h0000, 1'b1, 12'h0064);
    cbr <= 2'h1;
    load;
    samp(10'h000, 10'h000, 12'h0000, 1'b1, 12'h0000);
  endtask
  task automatic t_sel;
    vsf <= 12'h0000;
    vsp <= 7'h00;
    vep <= 7'h64;
    csf <= 12'h0000;
    csp <= 7'h00;
    cep <= 7'h64;
    for (int i = 0; i < 8; i++) begin
      sel <= 2'(i >> 1);
      load;
      samp(10'h3FF, 10'h3FF, 12'h007B, i[0], sel_exp[i]);
    end
  endtask
  task automatic t_avg;
    rst;
    filt <= 5'h04;
    sel <= 2'h2;
    slow <= 1'b1;
    load;
    for (int i = 0; i < 5; i++) begin
      samp(10'h000, 10'h000, avg_in[i], 1'b1, avg_exp[i]);
    end
  endtask
  task automatic t_dead;
    rst;
    filt <= 5'h11;
    slow <= 1'b0;
    load;
    repeat (17) samp(10'h000, 10'h000, 12'h03E8, 1'b1, 12'h03E8);
    for (int i = 0; i < 4; i++) begin
      samp(10'h000, 10'h000, db_in[i], 1'b1, db_exp[i]);
    end
  endtask
  initial begin
    t_defaults;
    filt <= 5'h01;
    t_scale;
    t_sel;
    t_avg;
    t_dead;
    print_verdict;
  end
  initial begin
    repeat (5000) @(posedge sys_clk);
    failures++;
    print_verdict;
  end
endmodule // asrc_top_tb
`default_nettype wire
